/* File: common/scic_pkg.sv */
// Purpose: constants for the two-channel serial control block
// Assumes: 125 MHz MCLK, AXI4-Lite register access
// Notes: one register window of 0x20 bytes per channel
package scic_pkg;
  localparam int NCH = 2;
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_CTRL   = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_TXDATA = 8'h0C;
  localparam logic [7:0] OFF_RXDATA = 8'h10;
  localparam logic [7:0] OFF_PORT   = 8'h14;
  localparam logic [7:0] OFF_BAUD   = 8'h18;
  localparam logic [7:0] OFF_STOP   = 8'h40;
  localparam logic [7:0] CH_STRIDE  = 8'h20;
  // control register fields
  localparam int C_TXIE = 7;
  localparam int C_RXIE = 6;
  localparam int C_TE   = 5;
  localparam int C_RE   = 4;
  localparam int C_TX_DONE_IRQ_ENABLE = 2;
  localparam int C_CLOCK_SRC_SEL_HI = 1;
  // status register fields
  localparam int S_TX_DATA_EMPTY_FLAG = 7;
  localparam int S_RX_FULL_FLAG = 6;
  localparam int S_OVERRUN_ERROR_FLAG = 5;
  localparam int S_FER  = 4;
  localparam int S_PER  = 3;
  localparam int S_TX_END_FLAG = 2;
  // mode register: bit 7 selects clock-synchronous
  localparam int M_SYNC = 7;
  // port register: bit0 level, bit1 drive
  localparam int P_LVL = 0;
  localparam int P_DIR = 1;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam int BAUD_DEF = 4;
endpackage

/* File: common/scic_bus_if.sv */
`timescale 1ns/1ps
// Purpose: register access strobes from bus slave to channel
// Assumes: single clock MCLK
// Notes: wr and rd are one-cycle pulses
interface scic_bus_if;
  logic       wr;
  logic       rd;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic       transfer_controller;
  logic [7:0] rdata;
  modport master (output wr, output rd, output addr, output wdata, output transfer_controller, input rdata);
  modport slave  (input wr, input rd, input addr, input wdata, input transfer_controller, output rdata);
endinterface

/* File: hw/scic_sync2.sv */
`timescale 1ns/1ps
// Purpose: two-flop synchroniser for pin inputs
// Assumes: input asynchronous to clk
// Notes: first stage read only by second
module scic_sync2 #(parameter int W = 1)
(
  input  wire logic         clk,   // clock
  input  wire logic         rst,   // sync reset
  input  wire logic [W-1:0] d,     // async in
  output logic      [W-1:0] q      // synced out
);
  logic [W-1:0] meta;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= '1;
      q    <= '1;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

/* File: hw/scic_chan.sv */
`timescale 1ns/1ps
// Purpose: one serial channel, clock-synchronous 8-bit shifter with flags
// Assumes: sclk_s and rxd_s already synchronised to clk
// Notes: internal clock derived from baud divider when not external
module scic_chan
(
  input  wire logic   clk,       // clock
  input  wire logic   rst,       // reset incl. module stop
  scic_bus_if.slave   bus,       // register strobes
  input  wire logic   sclk_s,    // synced external clock
  input  wire logic   rxd_s,     // synced receive line
  output logic        txd,       // tx pin out
  output logic        txd_oe_n,  // tx pin enable, low drives
  output logic        sck,       // clock pin out
  output logic        sck_oe_n,  // clock pin enable, low drives
  output logic [3:0]  irq        // err, rx, tx, tx_end_flag
);
  logic [7:0] mode, ctrl, baud, port, tx_data_reg, tx_shift_reg, rx_data_reg, rx_shift;
  logic tx_data_empty_flag, rx_full_flag, overrun_error_flag, frame_error_flag, parity_error_flag, tx_end_flag;
  logic [2:0] tbit, rbit;
  logic tbusy, rbusy;
  logic [7:0] div;
  logic iclk, ext, clk_q, rise, fall, te, re, sync_m;

  assign te     = ctrl[scic_pkg::C_TE];
  assign re     = ctrl[scic_pkg::C_RE];
  assign sync_m = mode[scic_pkg::M_SYNC];
  assign ext    = ctrl[scic_pkg::C_CLOCK_SRC_SEL_HI];

  wire sel_clk = ext ? sclk_s : iclk;
  assign rise = sel_clk & ~clk_q;
  assign fall = ~sel_clk & clk_q;

  wire wr_mode = bus.wr && bus.addr == scic_pkg::OFF_MODE[4:0];
  wire wr_ctrl = bus.wr && bus.addr == scic_pkg::OFF_CTRL[4:0];
  wire wr_stat = bus.wr && bus.addr == scic_pkg::OFF_STATUS[4:0];
  wire wr_tdr  = bus.wr && bus.addr == scic_pkg::OFF_TXDATA[4:0];
  wire rd_rdr  = bus.rd && bus.addr == scic_pkg::OFF_RXDATA[4:0];
  wire err_any = overrun_error_flag | frame_error_flag | parity_error_flag;
  // errors hold off tx start in sync mode
  // last bit stays out until the eighth rising edge, so a back-to-back load waits for it
  wire shift_done = tbusy && rise && tbit == 3'h7;
  wire load = te && !tx_data_empty_flag && !(sync_m && err_any) && (!tbusy || shift_done);
  wire rx_done = re && rise && rbit == 3'h7;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode <= 8'h00;
      ctrl <= 8'h00;
      baud <= 8'(scic_pkg::BAUD_DEF);
      port <= 8'h00;
    end
    else
    begin
      if (wr_mode)
        mode <= bus.wdata;
      if (wr_ctrl)
        ctrl <= bus.wdata;
      if (bus.wr && bus.addr == scic_pkg::OFF_BAUD[4:0])
        baud <= bus.wdata;
      if (bus.wr && bus.addr == scic_pkg::OFF_PORT[4:0])
        port <= bus.wdata;
    end
  end

  // internal clock, idles high unless transmitting or receiving with rx_full_flag clear
  always_ff @(posedge clk)
  begin
    if (rst || !(tbusy || (re && !rx_full_flag)) || ext)
    begin
      div  <= 8'h00;
      iclk <= 1'b1;
    end
    else if (div >= baud)
    begin
      div  <= 8'h00;
      iclk <= ~iclk;
    end
    else
      div <= div + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      clk_q <= 1'b1;
    else
      clk_q <= sel_clk;
  end

  // transmitter
  always_ff @(posedge clk)
  begin
    if (rst || !te)
    begin
      tx_shift_reg   <= 8'hFF;
      tbit  <= 3'h0;
      tbusy <= 1'b0;
      tx_end_flag  <= 1'b1;
    end
    else if (load)
    begin
      tx_shift_reg   <= tx_data_reg;
      tbit  <= 3'h0;
      tbusy <= 1'b1;
      tx_end_flag  <= 1'b0;
    end
    else if (tbusy && rise)
    begin
      tbit <= tbit + 3'h1;
      if (tbit == 3'h7)
      begin
        tbusy <= 1'b0;
        tx_end_flag  <= 1'b1;
      end
    end
    // bit 0 is out from load: the first falling edge only opens the frame
    else if (tbusy && fall && tbit != 3'h0)
      tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
    else if (wr_stat && !bus.wdata[scic_pkg::S_TX_END_FLAG] && !tbusy)
      tx_end_flag <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      tx_data_reg <= 8'h00;
    else if (wr_tdr)
      tx_data_reg <= bus.wdata;
  end

  // tx_data_empty_flag: set on load or tx disable; set beats clear
  always_ff @(posedge clk)
  begin
    if (rst || !te || load)
      tx_data_empty_flag <= 1'b1;
    else if (wr_tdr && bus.transfer_controller)
      tx_data_empty_flag <= 1'b0;
    else if (wr_stat && !bus.wdata[scic_pkg::S_TX_DATA_EMPTY_FLAG])
      tx_data_empty_flag <= 1'b0;
  end

  // receiver; clearing enable leaves flags alone
  always_ff @(posedge clk)
  begin
    if (rst || !re)
    begin
      rx_shift  <= 8'h00;
      rbit <= 3'h0;
    end
    // keeps shifting while full, else an overrun could never be seen
    else if (rise && !err_any)
    begin
      rx_shift  <= {rxd_s, rx_shift[7:1]};
      rbit <= rbit + 3'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_data_reg  <= 8'h00;
      rx_full_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
      frame_error_flag  <= 1'b0;
      parity_error_flag  <= 1'b0;
    end
    else
    begin
      if (rx_done && !rx_full_flag && !err_any)
      begin
        rx_data_reg  <= {rxd_s, rx_shift[7:1]};
        rx_full_flag <= 1'b1;
        // all-zero character taken as break, except in sync mode
        if ({rxd_s, rx_shift[7:1]} == 8'h00 && !sync_m)
          frame_error_flag <= 1'b1;
      end
      else if ((rd_rdr && bus.transfer_controller) || (wr_stat && !bus.wdata[scic_pkg::S_RX_FULL_FLAG]))
        rx_full_flag <= 1'b0;
      if (rx_done && rx_full_flag)
        overrun_error_flag <= 1'b1;
      else if (wr_stat && !bus.wdata[scic_pkg::S_OVERRUN_ERROR_FLAG])
        overrun_error_flag <= 1'b0;
      if (wr_stat && !bus.wdata[scic_pkg::S_FER] && !(rx_done && !rx_full_flag))
        frame_error_flag <= 1'b0;
      if (wr_stat && !bus.wdata[scic_pkg::S_PER])
        parity_error_flag <= 1'b0;
    end
  end

  // pins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      txd      <= 1'b1;
      txd_oe_n <= 1'b1;
      sck      <= 1'b1;
      sck_oe_n <= 1'b1;
    end
    else
    begin
      // line holds the last bit after a frame; an undriven pin shows mark
      txd      <= te ? tx_shift_reg[0] : (port[scic_pkg::P_DIR] ? port[scic_pkg::P_LVL] : 1'b1);
      txd_oe_n <= te ? 1'b0 : ~port[scic_pkg::P_DIR];
      sck      <= iclk;
      sck_oe_n <= ext | ~(te | re);
    end
  end

  // one request line per source; err and rx full share the RXIE enable
  always_ff @(posedge clk)
  begin
    if (rst)
      irq <= 4'h0;
    else
    begin
      irq[3] <= ctrl[scic_pkg::C_RXIE] & err_any;
      irq[2] <= ctrl[scic_pkg::C_RXIE] & rx_full_flag;
      irq[1] <= ctrl[scic_pkg::C_TXIE] & te & tx_data_empty_flag;
      irq[0] <= ctrl[scic_pkg::C_TX_DONE_IRQ_ENABLE] & tx_end_flag & ~(ctrl[scic_pkg::C_TXIE] & te & tx_data_empty_flag);
    end
  end

  always_comb
  begin
    unique case (bus.addr)
      scic_pkg::OFF_MODE[4:0]:   bus.rdata = mode;
      scic_pkg::OFF_CTRL[4:0]:   bus.rdata = ctrl;
      scic_pkg::OFF_STATUS[4:0]: bus.rdata = {tx_data_empty_flag, rx_full_flag, overrun_error_flag, frame_error_flag, parity_error_flag, tx_end_flag, 2'h0};
      scic_pkg::OFF_TXDATA[4:0]: bus.rdata = tx_data_reg;
      scic_pkg::OFF_RXDATA[4:0]: bus.rdata = rx_data_reg;
      scic_pkg::OFF_PORT[4:0]:   bus.rdata = port;
      scic_pkg::OFF_BAUD[4:0]:   bus.rdata = baud;
      default:                   bus.rdata = 8'h00;
    endcase
  end
endmodule

/* File: hw/scic_top.sv */
`timescale 1ns/1ps
// Purpose: AXI4-Lite register slave and two serial channels
// Assumes: MCLK 125 MHz, RST synchronous active high
// Notes: module stop register gates each channel, set at reset
module scic_top
(
  input  wire logic        MCLK,          // clock
  input  wire logic        RST,           // sync reset
  input  wire logic [7:0]  AWADDR,        // write address
  input  wire logic        AWVALID,       // write address valid
  output logic             AWREADY,       // write address ready
  input  wire logic [31:0] WDATA,         // write data
  input  wire logic [3:0]  WSTRB,         // byte strobes
  input  wire logic        WVALID,        // write data valid
  output logic             WREADY,        // write data ready
  output logic [1:0]       BRESP,         // write response
  output logic             BVALID,        // write response valid
  input  wire logic        BREADY,        // write response ready
  input  wire logic [7:0]  ARADDR,        // read address
  input  wire logic        ARVALID,       // read address valid
  output logic             ARREADY,       // read address ready
  output logic [31:0]      RDATA,         // read data
  output logic [1:0]       RRESP,         // read response
  output logic             RVALID,        // read valid
  input  wire logic        RREADY,        // read ready
  input  wire logic [2:0]  AWPROT,        // unused protection
  input  wire logic [2:0]  ARPROT,        // unused protection
  input  wire logic        DTC_ACCESS,    // access made by transfer controller
  input  wire logic [1:0]  SCK_IN,        // clock pins in
  input  wire logic [1:0]  RXD,           // receive pins
  output logic      [1:0]  TXD,           // transmit pins out
  output logic      [1:0]  TXD_OE_N,      // transmit pin enables
  output logic      [1:0]  SCK_OUT,       // clock pins out
  output logic      [1:0]  SCK_OE_N,      // clock pin enables
  output logic      [1:0]  IRQ_RX_ERR,    // receive error requests
  output logic      [1:0]  IRQ_RX_FULL,   // receive full requests
  output logic      [1:0]  IRQ_TX_EMPTY,  // transmit empty requests
  output logic      [1:0]  IRQ_TX_DONE    // transmit end requests
);
  logic [1:0] stop;
  logic [7:0] aw_a, rd_a;
  logic aw_h, w_h, wr_go, rd_go, dtc_q;
  logic [7:0] wd;
  logic [1:0] sck_s, rxd_s;
  logic [3:0] irq [2];
  logic [1:0] txd_i, txd_oe_i, sck_i, sck_oe_i;

  scic_sync2 #(.W(4)) u_sync
  (
    .clk (MCLK),
    .rst (RST),
    .d   ({SCK_IN, RXD}),
    .q   ({sck_s, rxd_s})
  );

  // write channel: address and data taken in either order
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      aw_h <= 1'b0;
      w_h  <= 1'b0;
      aw_a <= 8'h00;
      wd   <= 8'h00;
      BVALID <= 1'b0;
      BRESP  <= scic_pkg::RESP_OK;
      dtc_q  <= 1'b0;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_h <= 1'b1;
        aw_a <= AWADDR;
        dtc_q <= DTC_ACCESS;
      end
      if (WVALID && WREADY)
      begin
        w_h <= 1'b1;
        wd  <= WSTRB[0] ? WDATA[7:0] : 8'h00;
      end
      if (wr_go)
      begin
        aw_h   <= 1'b0;
        w_h    <= 1'b0;
        BVALID <= 1'b1;
        BRESP  <= (aw_a[7:6] > 2'h1) ? scic_pkg::RESP_ERR : scic_pkg::RESP_OK;
      end
      else if (BVALID && BREADY)
        BVALID <= 1'b0;
    end
  end
  assign wr_go = aw_h && w_h && !BVALID;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      ARREADY <= 1'b0;
    end
    else
    begin
      AWREADY <= !aw_h && !(AWVALID && AWREADY) && !BVALID;
      WREADY  <= !w_h && !(WVALID && WREADY) && !BVALID;
      ARREADY <= !RVALID && !(ARVALID && ARREADY) && !rd_go;
    end
  end

  // module stop, halted after reset
  always_ff @(posedge MCLK)
  begin
    if (RST)
      stop <= 2'h3;
    else if (wr_go && aw_a == scic_pkg::OFF_STOP)
      stop <= wd[1:0];
  end

  // read: address registered, data one cycle later
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      rd_go <= 1'b0;
      rd_a  <= 8'h00;
    end
    else
    begin
      rd_go <= ARVALID && ARREADY;
      if (ARVALID && ARREADY)
        rd_a <= ARADDR;
    end
  end

  scic_bus_if bi [2] ();

  genvar g;
  generate
    for (g = 0; g < scic_pkg::NCH; g++)
    begin : g_ch
      wire sel_w = aw_a[7:5] == 3'(g) && !stop[g];
      wire sel_r = rd_a[7:5] == 3'(g) && !stop[g];
      assign bi[g].wr    = wr_go && sel_w;
      assign bi[g].rd    = rd_go && sel_r;
      assign bi[g].addr  = bi[g].wr ? aw_a[4:0] : rd_a[4:0];
      assign bi[g].wdata = wd;
      assign bi[g].transfer_controller   = bi[g].wr ? dtc_q : DTC_ACCESS;
      // each channel keeps its own flags and requests
      scic_chan u_ch
      (
        .clk      (MCLK),
        .rst      (RST | stop[g]),
        .bus      (bi[g]),
        .sclk_s   (sck_s[g]),
        .rxd_s    (rxd_s[g]),
        .txd      (txd_i[g]),
        .txd_oe_n (txd_oe_i[g]),
        .sck      (sck_i[g]),
        .sck_oe_n (sck_oe_i[g]),
        .irq      (irq[g])
      );
    end
  endgenerate

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= scic_pkg::RESP_OK;
      TXD <= 2'h3;
      TXD_OE_N <= 2'h3;
      SCK_OUT <= 2'h3;
      SCK_OE_N <= 2'h3;
      IRQ_RX_ERR <= 2'h0;
      IRQ_RX_FULL <= 2'h0;
      IRQ_TX_EMPTY <= 2'h0;
      IRQ_TX_DONE <= 2'h0;
    end
    else
    begin
      if (rd_go)
      begin
        RVALID <= 1'b1;
        RRESP  <= (rd_a[7:6] > 2'h1) ? scic_pkg::RESP_ERR : scic_pkg::RESP_OK;
        if (rd_a == scic_pkg::OFF_STOP)
          RDATA <= {30'h0, stop};
        else if (rd_a[5] == 1'b0 && !rd_a[6] && !rd_a[7] && !stop[0])
          RDATA <= {24'h0, bi[0].rdata};
        else if (rd_a[7:5] == 3'h1 && !stop[1])
          RDATA <= {24'h0, bi[1].rdata};
        else
          RDATA <= 32'h0000_0000;
      end
      else if (RVALID && RREADY)
        RVALID <= 1'b0;
      TXD <= txd_i;
      TXD_OE_N <= txd_oe_i;
      SCK_OUT <= sck_i;
      SCK_OE_N <= sck_oe_i;
      IRQ_RX_ERR   <= {irq[1][3], irq[0][3]};
      IRQ_RX_FULL  <= {irq[1][2], irq[0][2]};
      IRQ_TX_EMPTY <= {irq[1][1], irq[0][1]};
      IRQ_TX_DONE  <= {irq[1][0], irq[0][0]};
    end
  end
endmodule

/* File: bench/scic_top_asserts.sv */
// Purpose: port checks on the two-channel serial control block
// Assumes: one clock domain, RST synchronous active high
// Notes: transfer-controller checks watch channel 0 only
`timescale 1ns/1ps
module scic_top_asserts
(
  input wire logic        MCLK,          // clock
  input wire logic        RST,           // sync reset
  input wire logic [7:0]  AWADDR,        // write address
  input wire logic        AWVALID,       // write address valid
  input wire logic        AWREADY,       // write address ready
  input wire logic        WVALID,        // write data valid
  input wire logic        WREADY,        // write data ready
  input wire logic [1:0]  BRESP,         // write response
  input wire logic        BVALID,        // write response valid
  input wire logic        BREADY,        // write response ready
  input wire logic [7:0]  ARADDR,        // read address
  input wire logic        ARVALID,       // read address valid
  input wire logic        ARREADY,       // read address ready
  input wire logic [31:0] RDATA,         // read data
  input wire logic [1:0]  RRESP,         // read response
  input wire logic        RVALID,        // read valid
  input wire logic        RREADY,        // read ready
  input wire logic        DTC_ACCESS,    // transfer controller access
  input wire logic [1:0]  TXD,           // transmit pins
  input wire logic [1:0]  IRQ_RX_ERR,    // error requests
  input wire logic [1:0]  IRQ_RX_FULL,   // rx full requests
  input wire logic [1:0]  IRQ_TX_EMPTY,  // tx empty requests
  input wire logic [1:0]  IRQ_TX_DONE    // tx end requests
);
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (RST);
  sequence wr_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence dtc_tx_wr;
    AWVALID && AWREADY && DTC_ACCESS && AWADDR == scic_pkg::OFF_TXDATA && IRQ_TX_EMPTY[0];
  endsequence
  sequence dtc_rx_rd;
    ARVALID && ARREADY && DTC_ACCESS && ARADDR == scic_pkg::OFF_RXDATA && IRQ_RX_FULL[0];
  endsequence
  reset_state_a: assert property (disable iff (1'b0) RST |=>
    (IRQ_TX_EMPTY | IRQ_TX_DONE | IRQ_RX_FULL | IRQ_RX_ERR) == 2'h0 && TXD == 2'h3 && !BVALID && !RVALID)
    else $error("outputs not at reset values");
  tx_priority_a: assert property ((IRQ_TX_EMPTY & IRQ_TX_DONE) == 2'h0)
    else $error("tx end request beside tx empty request");
  b_answer_a: assert property (wr_taken |-> ##[1:2] BVALID)
    else $error("write response late");
  b_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  r_answer_a: assert property (ARVALID && ARREADY |-> ##2 RVALID)
    else $error("read data not two cycles after address");
  r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  r_error_a: assert property (ARVALID && ARREADY && ARADDR[7] |-> ##2 RRESP == scic_pkg::RESP_ERR)
    else $error("unmapped read not refused");
  upper_zero_a: assert property (RVALID |-> RDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  dtc_tx_clear_a: assert property (dtc_tx_wr |-> ##[1:4] !IRQ_TX_EMPTY[0])
    else $error("tx empty not cleared by transfer write");
  dtc_rx_clear_a: assert property (dtc_rx_rd |-> ##[1:6] !IRQ_RX_FULL[0])
    else $error("rx full not cleared by transfer read");
endmodule

/* File: bench/scic_far_station.sv */
// Purpose: remote clock-synchronous station on channel 0
// Assumes: station supplies the link clock, 160 ns period
// Notes: clock idles high outside frames
`timescale 1ns/1ps
module scic_far_station
(
  input  wire logic clk,  // device clock, spacing only
  input  wire logic txd,  // device transmit pin
  output logic      sck,  // link clock
  output logic      rxd   // line into device
);
  initial
  begin
    sck = 1'b1;
    rxd = 1'b1;
  end
  task automatic xfer(input logic [7:0] txb, output logic [7:0] got);
    repeat (5) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      sck = 1'b0;
      rxd = txb[i];
      #80;
      sck = 1'b1;
      got[i] = txd;
      #80;
    end
    // released line: no pull, so show a changed level
    rxd = ~rxd;
  endtask
endmodule

/* File: bench/testbench.sv */
// Purpose: self-checking bench for the serial control block
// Assumes: AXI4-Lite master tasks, station on channel 0
// Notes: channel 1 stays in module stop
`timescale 1ns/1ps
module testbench;
  logic MCLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, DTC_ACCESS, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [7:0]  AWADDR, ARADDR, got, rdata;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, rresp, TXD, TXD_OE_N, SCK_OUT, SCK_OE_N;
  logic [1:0]  IRQ_RX_ERR, IRQ_RX_FULL, IRQ_TX_EMPTY, IRQ_TX_DONE;
  logic        far_sck, far_rxd;
  int          miscompares, check_count;
  scic_top scic_top_inst (.MCLK(MCLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .AWPROT(3'h0), .ARPROT(3'h0), .DTC_ACCESS(DTC_ACCESS),
    .SCK_IN({1'b1, far_sck}), .RXD({1'b1, far_rxd}), .TXD(TXD), .TXD_OE_N(TXD_OE_N), .SCK_OUT(SCK_OUT),
    .SCK_OE_N(SCK_OE_N), .IRQ_RX_ERR(IRQ_RX_ERR), .IRQ_RX_FULL(IRQ_RX_FULL), .IRQ_TX_EMPTY(IRQ_TX_EMPTY),
    .IRQ_TX_DONE(IRQ_TX_DONE));
  scic_far_station scic_far_station_inst (.clk(MCLK), .txd(TXD[0]), .sck(far_sck), .rxd(far_rxd));
  task automatic chk(input bit ok, input string m);
    check_count++;
    if (!ok)
    begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic transfer_controller);
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= {24'h0, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    DTC_ACCESS <= transfer_controller;
    do
    begin
      @(posedge MCLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    BREADY <= 1'b0;
    DTC_ACCESS <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic transfer_controller);
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    DTC_ACCESS <= transfer_controller;
    do
    begin
      @(posedge MCLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    rdata = RDATA[7:0];
    rresp = RRESP;
    RREADY <= 1'b0;
    DTC_ACCESS <= 1'b0;
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return IRQ_TX_EMPTY[0];
      1: return IRQ_TX_DONE[0];
      2: return IRQ_RX_FULL[0];
      3: return IRQ_RX_ERR[0];
      4: return TXD[0];
      default: return TXD_OE_N[0];
    endcase
  endfunction
  task automatic wait_sig(input int k, input logic v, input int lim);
    for (int n = 0; n < lim && pick(k) !== v; n++) @(posedge MCLK);
    chk(pick(k) === v, "pin or request did not reach level");
  endtask
  task automatic scen_stop();
    rd(scic_pkg::OFF_STOP, 1'b0);
    chk(rdata === 8'h03, "stop reset value");
    wr(scic_pkg::OFF_CTRL, 8'hFF, 1'b0);
    rd(scic_pkg::OFF_CTRL, 1'b0);
    chk(rdata === 8'h00, "stopped channel took write");
    rd(8'h80, 1'b0);
    chk(rresp === scic_pkg::RESP_ERR, "unmapped read accepted");
    wr(scic_pkg::OFF_STOP, 8'h02, 1'b0);
  endtask
  task automatic scen_xfer();
    wr(scic_pkg::OFF_MODE, 8'h80, 1'b0);
    wr(scic_pkg::OFF_CTRL, 8'hF2, 1'b0);
    wait_sig(0, 1'b1, 10);
    wr(scic_pkg::OFF_TXDATA, 8'hA5, 1'b1);
    scic_far_station_inst.xfer(8'h3C, got);
    chk(got === 8'hA5, "sent byte wrong");
    wait_sig(2, 1'b1, 20);
    rd(scic_pkg::OFF_RXDATA, 1'b1);
    chk(rdata === 8'h3C, "received byte wrong");
    wait_sig(2, 1'b0, 10);
    chk(IRQ_TX_EMPTY[1] === 1'b0 && IRQ_RX_FULL[1] === 1'b0, "idle channel requests");
  endtask
  task automatic scen_error_block();
    scic_far_station_inst.xfer(8'h11, got);
    scic_far_station_inst.xfer(8'h22, got);
    wait_sig(3, 1'b1, 20);
    wr(scic_pkg::OFF_TXDATA, 8'h5A, 1'b1);
    repeat (40) @(posedge MCLK);
    chk(IRQ_TX_EMPTY[0] === 1'b0, "tx started under receive error");
    wr(scic_pkg::OFF_TXDATA, 8'h66, 1'b0);
    wr(scic_pkg::OFF_STATUS, 8'h87, 1'b0);
    wait_sig(3, 1'b0, 10);
    wait_sig(0, 1'b1, 50);
    scic_far_station_inst.xfer(8'h00, got);
    chk(got === 8'h66, "overwritten byte not sent");
  endtask
  task automatic scen_irq_mask();
    wr(scic_pkg::OFF_CTRL, 8'h00, 1'b0);
    wr(scic_pkg::OFF_CTRL, 8'hA6, 1'b0);
    wait_sig(0, 1'b1, 10);
    chk(IRQ_TX_DONE[0] === 1'b0, "tx end beside tx empty");
    wr(scic_pkg::OFF_CTRL, 8'h00, 1'b0);
    wr(scic_pkg::OFF_CTRL, 8'h26, 1'b0);
    wait_sig(1, 1'b1, 10);
    chk(IRQ_TX_EMPTY[0] === 1'b0, "masked tx empty request");
  endtask
  task automatic scen_port_and_stop();
    wr(scic_pkg::OFF_CTRL, 8'h00, 1'b0);
    wr(scic_pkg::OFF_CTRL, 8'h02, 1'b0);
    wr(scic_pkg::OFF_PORT, 8'h02, 1'b0);
    wr(scic_pkg::OFF_CTRL, 8'h00, 1'b0);
    chk(SCK_OE_N[0] === 1'b1 && SCK_OUT[0] === 1'b1, "clock pin glitched on release");
    wait_sig(5, 1'b0, 10);
    chk(TXD[0] === 1'b0, "break level not driven");
    wr(scic_pkg::OFF_PORT, 8'h03, 1'b0);
    wait_sig(4, 1'b1, 10);
    wr(scic_pkg::OFF_MODE, 8'h00, 1'b0);
    wr(scic_pkg::OFF_STATUS, 8'h87, 1'b0);
    wr(scic_pkg::OFF_CTRL, 8'h52, 1'b0);
    scic_far_station_inst.xfer(8'h00, got);
    wait_sig(2, 1'b1, 20);
    wait_sig(3, 1'b1, 20);
    wr(scic_pkg::OFF_STOP, 8'h03, 1'b0);
    wr(scic_pkg::OFF_STOP, 8'h02, 1'b0);
    rd(scic_pkg::OFF_STATUS, 1'b0);
    chk(rdata[6:3] === 4'h0 && IRQ_RX_FULL[0] === 1'b0, "rx side kept state");
    chk(TXD[0] === 1'b1 && TXD_OE_N[0] === 1'b1, "line not high after stop");
    wr(scic_pkg::CH_STRIDE + scic_pkg::OFF_CTRL, 8'hFF, 1'b0);
    rd(scic_pkg::CH_STRIDE + scic_pkg::OFF_CTRL, 1'b0);
    chk(rdata === 8'h00 && IRQ_TX_EMPTY[1] === 1'b0, "stopped channel 1 active");
    wr(scic_pkg::OFF_CTRL, 8'hA0, 1'b0);
    wait_sig(0, 1'b1, 10);
  endtask
  initial
  begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  initial
  begin
    repeat (20000) @(posedge MCLK);
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end
  initial
  begin
    {RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, DTC_ACCESS} = 7'h40;
    {AWADDR, ARADDR, WDATA, WSTRB} = 52'h1;
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    repeat (2) @(posedge MCLK);
    scen_stop();
    scen_xfer();
    scen_error_block();
    scen_irq_mask();
    scen_port_and_stop();
    results();
  end
endmodule
bind scic_top scic_top_asserts scic_top_asserts_inst (.*);
